// ===== verilog/dfc_pkg.sv
// package: register map, field layout and carrier types for the drive bank
package dfc_pkg;

    // register byte offsets on the AXI4-Lite slave
    localparam logic [7:0]  DFC_OFF_OPCMD    = 8'h00;
    localparam logic [7:0]  DFC_OFF_FRQCMD   = 8'h04;
    localparam logic [7:0]  DFC_OFF_STATUS   = 8'h08;
    localparam logic [7:0]  DFC_OFF_OUTFRQ   = 8'h0C;
    localparam logic [7:0]  DFC_OFF_MAPSLOT0 = 8'h10;
    localparam logic [7:0]  DFC_OFF_IRQSTAT  = 8'h24;
    localparam logic [7:0]  DFC_OFF_IRQMASK  = 8'h28;

    // mapping slots and the common-area addresses that shadow the fixed path
    localparam int          DFC_NUM_SLOTS    = 5;
    localparam logic [15:0] DFC_CA_FREQ      = 16'h0380;
    localparam logic [15:0] DFC_CA_OPER      = 16'h0382;
    localparam logic [15:0] DFC_CA_NONE      = 16'h0000;

    // reset values
    localparam logic [15:0] DFC_RST_OPCMD    = 16'h0000;
    localparam logic [15:0] DFC_RST_FRQCMD   = 16'h0000;
    localparam logic [15:0] DFC_RST_SLOT     = 16'h0000;
    localparam logic [2:0]  DFC_RST_IRQ      = 3'h0;

    // operation command encodings
    localparam logic [15:0] DFC_OP_REVERSE   = 16'h0001;

    // status bit positions
    localparam int DFC_ST_STOP   = 0;
    localparam int DFC_ST_FWD    = 1;
    localparam int DFC_ST_REV    = 2;
    localparam int DFC_ST_TRIP   = 3;
    localparam int DFC_ST_ACC    = 4;
    localparam int DFC_ST_DEC    = 5;
    localparam int DFC_ST_SPDOK  = 6;
    localparam int DFC_ST_DCBRK  = 7;
    localparam int DFC_ST_FWDCMD = 11;
    localparam int DFC_ST_REVCMD = 12;
    localparam int DFC_ST_RUNCOM = 13;
    localparam int DFC_ST_FRQCOM = 14;
    localparam int DFC_ST_LOCAL  = 15;

    // interrupt status bits
    localparam int DFC_IRQ_TRIP  = 0;
    localparam int DFC_IRQ_SPDOK = 1;
    localparam int DFC_IRQ_STOP  = 2;

    localparam logic [1:0]  DFC_RESP_OKAY    = 2'b00;
    localparam logic [1:0]  DFC_RESP_SLVERR  = 2'b10;

    // command carrier toward the drive
    typedef struct packed {
        logic [15:0] freq_ref;
        logic        freq_valid;
        logic [15:0] oper_cmd;
        logic        oper_valid;
    } dfc_cmd_t;

    // state carrier from the drive
    typedef struct packed {
        logic [15:0] status;
        logic [15:0] out_freq;
    } dfc_mon_t;

    typedef enum logic [1:0] {
        DFC_W_IDLE = 2'b00,
        DFC_W_RESP = 2'b01
    } dfc_wr_state_t;

endpackage : dfc_pkg

// ===== verilog/dfc_slot_match.sv
// slot compare: flags any mapping slot holding a given common-area address
`timescale 1ns/100ps
module dfc_slot_match
    import dfc_pkg::*;
#(
    parameter int NSLOT = DFC_NUM_SLOTS
) (
    input  wire logic [NSLOT*16-1:0] slots,
    input  wire logic [15:0]         addr,
    output logic                     hit
);
    logic [NSLOT-1:0] match;

    genvar g;
    generate
        for (g = 0; g < NSLOT; g++) begin : g_slot
            assign match[g] = (slots[g*16 +: 16] == addr);
        end
    endgenerate

    assign hit = |match;

endmodule : dfc_slot_match

// ===== verilog/dfc_regs.sv
// drive fixed command/status register bank on an AXI4-Lite slave
//
// Operation
// - fixed command and status registers work without any mapping slot set.
// - frequency command value is forwarded as the drive frequency reference.
// - frequency command counts 0.01 Hz; software writes hertz times 100.
// - frequency command ignored while any write slot holds 0x0380.
// - operation command ignored while any write slot holds 0x0382.
// - operation command value 0x0001 commands reverse run.
// - status bit 3 reports drive trip, per the trip-out mode setting.
// - status bits 11 and 12 report forward and reverse run commands.
// - status bit 13 set when run command comes from communication.
// - status bit 14 set when frequency command comes from communication.
// - status bit 15 is 0 for remote, 1 for keypad local.
// - present output frequency shown in a read-only monitor register.
// - output frequency monitor counts 0.01 Hz, frequency times 100.
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module dfc_regs
    import dfc_pkg::*;
#(
    parameter int NSLOT = DFC_NUM_SLOTS
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // drive side
    output dfc_cmd_t         drv_cmd,
    output logic             drv_reverse,
    input  wire dfc_mon_t    drv_mon,
    output logic             irq
);
    logic [15:0]         opcmd_r;
    logic [15:0]         frqcmd_r;
    logic [NSLOT*16-1:0] slots_r;
    logic [15:0]         status_r;
    logic [15:0]         outfrq_r;
    logic [2:0]          irq_stat_r;
    logic [2:0]          irq_mask_r;
    logic [15:0]         status_prev_r;
    logic                freq_block;
    logic                oper_block;

    // write channel
    dfc_wr_state_t wst_r;
    logic [7:0]    awaddr_r;
    logic          aw_have_r;
    logic [31:0]   wdata_r;
    logic [3:0]    wstrb_r;
    logic          w_have_r;
    logic          wr_fire;
    logic          wr_hit;
    logic [1:0]    bresp_r;

    // readies drop while frozen, so no item is taken and then lost
    assign s_awready = clk_en && (wst_r == DFC_W_IDLE) && !aw_have_r;
    assign s_wready  = clk_en && (wst_r == DFC_W_IDLE) && !w_have_r;
    assign s_bvalid  = (wst_r == DFC_W_RESP);
    assign s_bresp   = bresp_r;
    assign wr_fire   = (wst_r == DFC_W_IDLE) && aw_have_r && w_have_r;

    // one decoded strobe per writable register except the mapping slots, which decode their own writes
    logic wr_opcmd;
    logic wr_frqcmd;
    logic wr_mask;
    assign wr_opcmd  = wr_fire && (awaddr_r == DFC_OFF_OPCMD);
    assign wr_frqcmd = wr_fire && (awaddr_r == DFC_OFF_FRQCMD);
    assign wr_mask   = wr_fire && (awaddr_r == DFC_OFF_IRQMASK);

    always_comb begin
        wr_hit = 1'b0;
        if (awaddr_r == DFC_OFF_OPCMD || awaddr_r == DFC_OFF_FRQCMD ||
            awaddr_r == DFC_OFF_IRQMASK) begin
            wr_hit = 1'b1;
        end
        for (int i = 0; i < NSLOT; i++) begin
            if (awaddr_r == DFC_OFF_MAPSLOT0 + 8'(4 * i)) begin
                wr_hit = 1'b1;
            end
        end
    end

    // address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else if (clk_en) begin
            if (s_awvalid && s_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r  <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_have_r <= 1'b1;
                wdata_r  <= s_wdata;
                wstrb_r  <= s_wstrb;
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_r   <= DFC_W_IDLE;
            bresp_r <= DFC_RESP_OKAY;
        end else if (clk_en) begin
            case (wst_r)
                DFC_W_IDLE: begin
                    if (wr_fire) begin
                        wst_r   <= DFC_W_RESP;
                        bresp_r <= wr_hit ? DFC_RESP_OKAY : DFC_RESP_SLVERR;
                    end
                end
                DFC_W_RESP: begin
                    if (s_bready) begin
                        wst_r <= DFC_W_IDLE;
                    end
                end
                default: wst_r <= DFC_W_IDLE;
            endcase
        end
    end

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        merge16 = old;
        if (s[0]) merge16[7:0]  = d[7:0];
        if (s[1]) merge16[15:8] = d[15:8];
    endfunction : merge16

    // fixed command registers, usable with no slot programmed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            opcmd_r  <= DFC_RST_OPCMD;
            frqcmd_r <= DFC_RST_FRQCMD;
        end else if (clk_en) begin
            if (wr_opcmd) begin
                opcmd_r <= merge16(opcmd_r, wdata_r, wstrb_r);
            end
            // raw 0.01 Hz counts stored unscaled
            if (wr_frqcmd) begin
                frqcmd_r <= merge16(frqcmd_r, wdata_r, wstrb_r);
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NSLOT; g++) begin : g_slot
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    slots_r[g*16 +: 16] <= DFC_RST_SLOT;
                end else if (clk_en && wr_fire &&
                             awaddr_r == DFC_OFF_MAPSLOT0 + 8'(4 * g)) begin
                    slots_r[g*16 +: 16] <=
                        merge16(slots_r[g*16 +: 16], wdata_r, wstrb_r);
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_r <= DFC_RST_IRQ;
        end else if (clk_en && wr_mask && wstrb_r[0]) begin
            irq_mask_r <= wdata_r[2:0];
        end
    end

    // slot mapping 0x0380 shadows frequency command
    dfc_slot_match #(.NSLOT(NSLOT)) u_freq_match (
        .slots (slots_r),
        .addr  (DFC_CA_FREQ),
        .hit   (freq_block)
    );

    // slot mapping 0x0382 shadows operation command
    dfc_slot_match #(.NSLOT(NSLOT)) u_oper_match (
        .slots (slots_r),
        .addr  (DFC_CA_OPER),
        .hit   (oper_block)
    );

    // drive command outputs from flip-flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drv_cmd     <= '0;
            drv_reverse <= 1'b0;
        end else if (clk_en) begin
            drv_cmd.freq_ref   <= frqcmd_r;
            drv_cmd.freq_valid <= !freq_block;
            drv_cmd.oper_cmd   <= opcmd_r;
            drv_cmd.oper_valid <= !oper_block;
            drv_reverse <= !oper_block && (opcmd_r == DFC_OP_REVERSE);
        end
    end

    // drive monitor capture, every enabled cycle without a request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r      <= 16'h0000;
            status_prev_r <= 16'h0000;
        end else if (clk_en) begin
            // trip bit passed as the drive reports it
            status_r      <= drv_mon.status;
            status_prev_r <= status_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            outfrq_r <= 16'h0000;
        end else if (clk_en) begin
            // drive already reports 0.01 Hz counts
            outfrq_r <= drv_mon.out_freq;
        end
    end

    // read channel: one outstanding read, answer a cycle after address
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0]  rresp_r;
    logic [1:0]  rresp_nxt;
    logic        rvalid_r;
    logic        rd_take;
    logic        rd_clr_irq;

    assign s_arready = clk_en && !rvalid_r;
    assign s_rvalid  = rvalid_r;
    assign s_rdata   = rdata_r;
    assign s_rresp   = rresp_r;
    assign rd_take   = s_arvalid && s_arready;
    assign rd_clr_irq = rd_take && (s_araddr == DFC_OFF_IRQSTAT);

    // read decode; unmapped offsets answer with an error and zero data
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = DFC_RESP_OKAY;
        case (s_araddr)
            DFC_OFF_OPCMD:   rdata_nxt[15:0] = opcmd_r;
            DFC_OFF_FRQCMD:  rdata_nxt[15:0] = frqcmd_r;
            DFC_OFF_STATUS:  rdata_nxt[15:0] = status_r;
            DFC_OFF_OUTFRQ:  rdata_nxt[15:0] = outfrq_r;
            DFC_OFF_IRQSTAT: rdata_nxt[2:0]  = irq_stat_r;
            DFC_OFF_IRQMASK: rdata_nxt[2:0]  = irq_mask_r;
            default: begin
                rresp_nxt = DFC_RESP_SLVERR;
                for (int i = 0; i < NSLOT; i++) begin
                    if (s_araddr == DFC_OFF_MAPSLOT0 + 8'(4 * i)) begin
                        rdata_nxt[15:0] = slots_r[i*16 +: 16];
                        rresp_nxt       = DFC_RESP_OKAY;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= DFC_RESP_OKAY;
        end else if (clk_en) begin
            if (rd_take) begin
                rvalid_r <= 1'b1;
                rresp_r  <= rresp_nxt;
                rdata_r  <= rdata_nxt;
            end else if (s_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // sticky events: rising trip, rising speed reached, rising stop
    // history resets to zero: a drive idling in stop gives one stop event
    logic [2:0] irq_evt;
    assign irq_evt[DFC_IRQ_TRIP]  = status_r[DFC_ST_TRIP] &&
                                    !status_prev_r[DFC_ST_TRIP];
    assign irq_evt[DFC_IRQ_SPDOK] = status_r[DFC_ST_SPDOK] &&
                                    !status_prev_r[DFC_ST_SPDOK];
    assign irq_evt[DFC_IRQ_STOP]  = status_r[DFC_ST_STOP] &&
                                    !status_prev_r[DFC_ST_STOP];

    // a new event beats the read-clear in the same cycle, so none is lost
    logic [2:0] irq_stat_nxt;
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (rd_clr_irq) begin
            irq_stat_nxt = 3'h0;
        end
        irq_stat_nxt = irq_stat_nxt | irq_evt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= DFC_RST_IRQ;
        end else if (clk_en) begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

endmodule : dfc_regs

// ===== testbench/dfc_regs_asserts.sv
// checker: bus handshakes, command forwarding and monitor mirroring
`timescale 1ns/100ps
module dfc_regs_asserts
    import dfc_pkg::*;
#(
    parameter int NSLOT = DFC_NUM_SLOTS
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_awaddr,
    input wire logic        s_awvalid,
    input wire logic        s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0]  s_wstrb,
    input wire logic        s_wvalid,
    input wire logic        s_wready,
    input wire logic [1:0]  s_bresp,
    input wire logic        s_bvalid,
    input wire logic        s_bready,
    input wire logic [7:0]  s_araddr,
    input wire logic        s_arvalid,
    input wire logic        s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic [1:0]  s_rresp,
    input wire logic        s_rvalid,
    input wire logic        s_rready,
    input wire dfc_cmd_t    drv_cmd,
    input wire logic        drv_reverse,
    input wire dfc_mon_t    drv_mon
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [15:0] wd_r;
    logic        ar_ok;
    // write data kept so the forwarded value can be compared later
    always_ff @(posedge aclk) begin
        if (s_wvalid && s_wready) begin
            wd_r <= s_wdata[15:0];
        end
    end
    assign ar_ok = s_arvalid && s_arready;
    a_read_answer: assert property (ar_ok |=> s_rvalid)
        else $error("read not answered one edge after address");
    a_write_resp: assert property (s_awvalid && s_awready && s_wvalid &&
        s_wready |-> ##2 s_bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (s_bvalid && !s_bready |=>
        s_bvalid && $stable(s_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_rvalid && !s_rready |=>
        s_rvalid && $stable(s_rdata))
        else $error("read data dropped early");
    a_status_mirror: assert property (ar_ok && s_araddr == DFC_OFF_STATUS
        && $stable(drv_mon) && $past(aresetn) |=>
        s_rdata == {16'h0000, $past(drv_mon.status)})
        else $error("status read differs from drive");
    a_outfrq_mirror: assert property (ar_ok && s_araddr == DFC_OFF_OUTFRQ
        && $stable(drv_mon) && $past(aresetn) |=>
        s_rdata == {16'h0000, $past(drv_mon.out_freq)})
        else $error("output frequency read differs from drive");
    a_freq_fwd: assert property (s_awvalid && s_awready && s_wvalid &&
        s_wready && s_awaddr == DFC_OFF_FRQCMD && s_wstrb[1:0] == 2'h3
        |-> ##[1:4] drv_cmd.freq_ref == wd_r)
        else $error("frequency command not forwarded");
    a_rev_cmd: assert property (drv_reverse == (drv_cmd.oper_valid &&
        drv_cmd.oper_cmd == DFC_OP_REVERSE))
        else $error("reverse output disagrees with command");
    a_unmapped_rd: assert property (ar_ok && s_araddr == 8'h30 |=>
        s_rresp == DFC_RESP_SLVERR && s_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule : dfc_regs_asserts
bind dfc_regs dfc_regs_asserts #(.NSLOT(NSLOT)) u_dfc_regs_asserts (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .drv_cmd(drv_cmd), .drv_reverse(drv_reverse),
    .drv_mon(drv_mon));

// ===== testbench/dfc_drv_model.sv
// drive-side model: runs at the reference, reports the status word
`timescale 1ns/100ps
module dfc_drv_model
    import dfc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire dfc_cmd_t    drv_cmd,
    input  wire logic        drv_reverse,
    input  wire logic [15:0] st_set,
    output dfc_mon_t         drv_mon
);
    logic [15:0] freq_r;
    // takes reference in 0.01 Hz counts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_r <= 16'h0000;
        end else if (drv_cmd.freq_valid) begin
            freq_r <= drv_cmd.freq_ref;
        end
    end
    // reverse request shows as reverse run command bit
    assign drv_mon = {st_set | {3'h0, drv_reverse, 12'h000}, freq_r};
endmodule : dfc_drv_model

// ===== testbench/drive_fixed_command_status_regs_tb.sv
// testbench for the drive command/status register bank
`timescale 1ns/100ps
module drive_fixed_command_status_regs_tb
    import dfc_pkg::*;
;
    logic aclk = 0, aresetn = 0, clk_en = 1;
    logic [7:0] s_awaddr = 0, s_araddr = 0;
    logic [31:0] s_wdata = 0, s_rdata, rd;
    logic [3:0] s_wstrb = 4'hF;
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
    logic s_rready = 0, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp, rs;
    logic [15:0] st_set = 0;
    dfc_cmd_t drv_cmd;
    dfc_mon_t drv_mon;
    logic drv_reverse, irq;
    int n_mismatch = 0, check_count = 0;
    always #5 aclk = ~aclk;
    dfc_regs u_dfc_regs (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready), .drv_cmd(drv_cmd),
        .drv_reverse(drv_reverse), .drv_mon(drv_mon), .irq(irq));
    dfc_drv_model u_dfc_drv_model (.aclk(aclk), .aresetn(aresetn),
        .drv_cmd(drv_cmd), .drv_reverse(drv_reverse), .st_set(st_set),
        .drv_mon(drv_mon));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_w
    task automatic chk_b(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_b
    task automatic hang;
        n_mismatch++;
        $display("[FAIL] %0t bus wait ran out", $time);
        complete_run();
    endtask : hang
    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask : settle
    // ready is looked at just before the edge that takes the item
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            aw = s_awvalid && s_awready;
            w = s_wvalid && s_wready;
            b = s_bvalid;
            rs = s_bresp;
            @(posedge aclk);
            if (aw) s_awvalid <= 1'b0;
            if (w) s_wvalid <= 1'b0;
            if (b) begin
                s_bready <= 1'b0;
                return;
            end
        end
        hang();
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        logic ar;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge aclk);
            ar = s_arvalid && s_arready;
            rd = s_rdata;
            rs = s_rresp;
            if (s_rvalid) begin
                @(posedge aclk);
                s_rready <= 1'b0;
                return;
            end
            @(posedge aclk);
            if (ar) s_arvalid <= 1'b0;
        end
        hang();
    endtask : axi_rd
    task automatic set_st(input logic [15:0] v);
        @(posedge aclk);
        st_set <= v;
        settle(3);
    endtask : set_st
    task automatic t_reset;
        axi_rd(DFC_OFF_OPCMD);
        chk_w(rd, 32'h0);
        axi_rd(DFC_OFF_FRQCMD);
        chk_w(rd, 32'h0);
        chk_b(drv_cmd.freq_valid & drv_cmd.oper_valid, 1'b1);
    endtask : t_reset
    task automatic t_freq;
        // 30 Hz is 3000 counts of 0.01 Hz
        axi_wr(DFC_OFF_FRQCMD, 32'h0000_0BB8);
        settle(2);
        chk_w({16'h0, drv_cmd.freq_ref}, 32'h0BB8);
        axi_rd(DFC_OFF_FRQCMD);
        chk_w(rd, 32'h0BB8);
        settle(2);
        axi_rd(DFC_OFF_OUTFRQ);
        chk_w(rd, 32'h0BB8);
    endtask : t_freq
    task automatic t_rev_shadow;
        axi_wr(DFC_OFF_OPCMD, 32'h1);
        settle(2);
        chk_b(drv_reverse, 1'b1);
        chk_w({16'h0, drv_cmd.oper_cmd}, 32'h1);
        axi_rd(DFC_OFF_STATUS);
        chk_w(rd, 32'h1000);
        for (int i = 0; i < DFC_NUM_SLOTS; i++) begin
            axi_wr(DFC_OFF_MAPSLOT0 + 8'(4 * i), {16'h0, DFC_CA_FREQ});
            settle(2);
            chk_b(drv_cmd.freq_valid, 1'b0);
            chk_b(drv_reverse, 1'b1);
            axi_wr(DFC_OFF_MAPSLOT0 + 8'(4 * i), {16'h0, DFC_CA_OPER});
            settle(2);
            chk_b(drv_cmd.oper_valid | drv_reverse, 1'b0);
            chk_b(drv_cmd.freq_valid, 1'b1);
            axi_wr(DFC_OFF_MAPSLOT0 + 8'(4 * i), {16'h0, DFC_CA_NONE});
            settle(2);
            chk_b(drv_reverse & drv_cmd.freq_valid, 1'b1);
        end
        axi_wr(DFC_OFF_OPCMD, 32'h0);
        settle(2);
        chk_b(drv_reverse, 1'b0);
    endtask : t_rev_shadow
    task automatic t_status;
        int bl[13] = '{0, 1, 2, 3, 4, 5, 6, 7, 11, 12, 13, 14, 15};
        foreach (bl[i]) begin
            set_st(16'h1 << bl[i]);
            axi_rd(DFC_OFF_STATUS);
            chk_w(rd, 32'h1 << bl[i]);
        end
    endtask : t_status
    task automatic t_irq;
        set_st(16'h0);
        axi_rd(DFC_OFF_IRQSTAT);
        axi_wr(DFC_OFF_IRQMASK, 32'h7);
        set_st(16'h0008);
        chk_b(irq, 1'b1);
        axi_rd(DFC_OFF_IRQSTAT);
        chk_w(rd, 32'h1);
        settle(1);
        chk_b(irq, 1'b0);
        // masked event is still recorded but stays quiet
        axi_wr(DFC_OFF_IRQMASK, 32'h0);
        set_st(16'h0040);
        chk_b(irq, 1'b0);
        axi_rd(DFC_OFF_IRQSTAT);
        chk_w(rd, 32'h2);
        set_st(16'h0001);
        axi_rd(DFC_OFF_IRQSTAT);
        chk_w(rd, 32'h4);
    endtask : t_irq
    // frozen clock enable: no capture and no bus readiness until released
    task automatic t_freeze;
        axi_wr(DFC_OFF_IRQMASK, 32'h1);
        @(posedge aclk);
        clk_en <= 1'b0;
        st_set <= 16'h0008;
        settle(4);
        chk_b(irq, 1'b0);
        chk_b(s_awready | s_wready | s_arready, 1'b0);
        @(posedge aclk);
        clk_en <= 1'b1;
        settle(3);
        chk_b(irq, 1'b1);
        axi_rd(DFC_OFF_IRQSTAT);
        chk_w(rd, 32'h1);
    endtask : t_freeze
    task automatic t_unmapped;
        axi_rd(8'h30);
        chk_w({30'h0, rs}, {30'h0, DFC_RESP_SLVERR});
        chk_w(rd, 32'h0);
        axi_wr(8'h30, 32'h1234);
        chk_w({30'h0, rs}, {30'h0, DFC_RESP_SLVERR});
    endtask : t_unmapped
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_freq();
        t_rev_shadow();
        t_status();
        t_irq();
        t_freeze();
        t_unmapped();
        complete_run();
    end
endmodule : drive_fixed_command_status_regs_tb
